// file: design/scm_top.v
// System clock source selection, clock monitor and quality check control.
//
// Contract
// - PLL clock = 2*osc*(mult+1)/(ref_divider_reg+1).
// - System clock from osc, PLL, or self-clock.
// - Peripheral clock runs at half system clock.
// - Flash arrays run at half system rate.
// - Each CAN picks peripheral or osc clock.
// - Timer and watchdog pick osc or PLL.
// - Monitor timeout: self-clock or system reset.
// - Monitor timeout comes from clockless RC delay.
// - No failure when disabled or edges present.
// - Quality checker counts edges in window.
// - Oscillator connected only after quality confirmed.
// - Failed start-up check enters self-clock mode.
// - Oscillator mode pin sampled at reset.
// - Oscillator halts only in full stop.
// - Self-clock from run needs both enables plus loss.
// - Self-clock holds until quality check passes.
// - System clock is PLL when select set.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.vh"
module scm_top #(
	parameter QC_WINDOW_CYC = `SCM_QC_WINDOW_CYC,
	parameter QC_EDGES      = `SCM_QC_EDGES,
	parameter OSC_KHZ       = `SCM_OSC_KHZ
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        osc_clock,
	input  wire        rc_timeout,
	input  wire        osc_select_pin,
	input  wire        wake_req,
	output wire        rc_restart,
	output reg  [1:0]  sys_src_sel,
	output wire        sys_clk_connected,
	output wire        pll_self_clock,
	output reg  [6:0]  pll_mult,
	output reg  [4:0]  pll_div,
	output wire        ips_clk_en,
	output wire        flash_array_en,
	output wire [1:0]  can_clk_osc,
	output wire        pit_clk_pll,
	output wire        swt_clk_pll,
	output wire        timer_clk_run,
	output wire        osc_enable,
	output wire        osc_loop_mode,
	output wire        doze_active,
	output wire        clk_mon_reset_req
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [2:0] ST_CHECK = 3'h0;
	localparam [2:0] ST_RUN   = 3'h1;
	localparam [2:0] ST_SELF  = 3'h2;
	localparam [2:0] ST_STOP  = 3'h3;
	localparam [2:0] ST_RESET = 3'h4;

	// ------------------------------------------------------------
	// Frequency arithmetic
	// ------------------------------------------------------------
	function [31:0] pll_khz;
		input [31:0] osc_khz;
		input [5:0]  mult;
		input [3:0]  rdiv;
		reg   [31:0] num;
		begin
			num     = osc_khz * {25'h0, ({1'b0, mult} + 7'h1)} * 32'h2;
			pll_khz = num / {27'h0, ({1'b0, rdiv} + 5'h1)};
		end
	endfunction

	// ------------------------------------------------------------
	// Registers and wires
	// ------------------------------------------------------------
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [5:0]  mult_reg;
	reg  [3:0]  ref_divider_reg_reg;
	reg  [5:0]  clock_select_reg_reg;
	reg         me_reg;
	reg         self_clock_enable_bit_reg;
	reg  [1:0]  mode_reg;
	reg         fail_flag_reg;
	reg         osc_d_reg;
	reg         half_reg;
	reg  [1:0]  strap_cnt_reg;
	reg         loop_mode_reg;
	reg  [31:0] rd_data;
	reg         rd_hit;
	wire [2:0]  sync_q;
	wire        osc_s;
	wire        rc_s;
	wire        sel_s;
	wire        osc_edge;
	wire        qc_busy;
	wire        qc_done;
	wire        qc_pass;
	wire        qc_start;
	wire        cm_loss;
	wire        wr_en;
	wire        rd_setup;
	wire        pll_sel;
	wire [31:0] pll_freq;
	wire [31:0] sys_freq;

	// ------------------------------------------------------------
	// Pin synchronisation and oscillator edge detection
	// ------------------------------------------------------------
	scm_sync #(
		.W (3)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({osc_select_pin, rc_timeout, osc_clock}),
		.q     (sync_q)
	);

	assign osc_s = sync_q[0];
	assign rc_s  = sync_q[1];
	assign sel_s = sync_q[2];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			osc_d_reg <= 1'b0;
		else
			osc_d_reg <= osc_s;
	end

	assign osc_edge = osc_s & ~osc_d_reg;

	// The strap is caught once the synchroniser has filled after the
	// release, so the reset value of the flops never reaches the oscillator.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_reg <= 2'h0;
			loop_mode_reg <= 1'b0;
		end else if (strap_cnt_reg != `SCM_STRAP_WAIT) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == `SCM_STRAP_WAIT - 2'h1)
				loop_mode_reg <= sel_s;
		end
	end

	assign osc_loop_mode = loop_mode_reg;

	// ------------------------------------------------------------
	// Clock quality checker
	// ------------------------------------------------------------
	assign qc_start = (state_reg == ST_CHECK || state_reg == ST_SELF) &&
		!qc_busy && !qc_done;

	scm_qual_check #(
		.WINDOW_CYC (QC_WINDOW_CYC),
		.EDGES      (QC_EDGES)
	) u_qc (
		.clk      (pclk),
		.rst_n    (presetn),
		.start    (qc_start),
		.osc_edge (osc_edge),
		.busy     (qc_busy),
		.done     (qc_done),
		.pass     (qc_pass)
	);

	// ------------------------------------------------------------
	// Clock monitor
	// ------------------------------------------------------------
	// The timeout itself is an analog RC delay; each seen edge restarts it while the monitor is enabled.
	assign rc_restart = me_reg & osc_edge;
	assign cm_loss = me_reg && rc_s && !osc_edge && state_reg == ST_RUN;

	// ------------------------------------------------------------
	// Control state machine
	// ------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_CHECK: begin
				if (qc_done)
					state_next = qc_pass ? ST_RUN : ST_SELF;
			end
			ST_RUN: begin
				if (cm_loss)
					state_next = self_clock_enable_bit_reg ? ST_SELF : ST_RESET;
				else if (mode_reg == `SCM_MODE_STOP)
					state_next = ST_STOP;
			end
			ST_SELF: begin
				if (qc_done && qc_pass)
					state_next = ST_RUN;
			end
			ST_STOP: begin
				if (wake_req)
					state_next = ST_CHECK;
			end
			ST_RESET: begin
				state_next = ST_RESET;
			end
			default: begin
				state_next = ST_CHECK;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= ST_CHECK;
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pslverr  = psel & penable & ~rd_hit;
	assign pll_sel  = clock_select_reg_reg[`SCM_CSEL_PLL];

	assign pll_freq = pll_khz(OSC_KHZ, mult_reg, ref_divider_reg_reg);
	assign sys_freq = pll_sel ? pll_freq : OSC_KHZ;

	always @* begin
		rd_hit  = 1'b1;
		rd_data = 32'h0;
		case (paddr)
			`SCM_OFF_MULT:    rd_data = {26'h0, mult_reg};
			`SCM_OFF_REF_DIVIDER_REG:  rd_data = {28'h0, ref_divider_reg_reg};
			`SCM_OFF_CLOCK_SELECT_REG:  rd_data = {26'h0, clock_select_reg_reg};
			`SCM_OFF_PLL_CONTROL_REG:  rd_data = {31'h0, me_reg};
			`SCM_OFF_IRQEN:   rd_data = {31'h0, self_clock_enable_bit_reg};
			`SCM_OFF_STATUS:  rd_data = {26'h0, loop_mode_reg, qc_busy,
				fail_flag_reg, pll_self_clock, sys_clk_connected};
			`SCM_OFF_MODE:    rd_data = {30'h0, mode_reg};
			`SCM_OFF_SYSFREQ: rd_data = sys_freq;
			`SCM_OFF_PLLFREQ: rd_data = pll_freq;
			default:          rd_hit  = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (rd_setup)
			prdata <= rd_data;
	end

	// Multiplier and divider are locked while the PLL drives the system,
	// so a running system clock never jumps. Range is not checked.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mult_reg   <= `SCM_RST_MULT;
			ref_divider_reg_reg <= `SCM_RST_REF_DIVIDER_REG;
			clock_select_reg_reg <= `SCM_RST_CLOCK_SELECT_REG;
			me_reg     <= `SCM_RST_ME;
			self_clock_enable_bit_reg   <= `SCM_RST_SELF_CLOCK_ENABLE_BIT;
		end else if (wr_en) begin
			if (paddr == `SCM_OFF_MULT && !pll_sel)
				mult_reg <= pwdata[5:0];
			if (paddr == `SCM_OFF_REF_DIVIDER_REG && !pll_sel)
				ref_divider_reg_reg <= pwdata[3:0];
			if (paddr == `SCM_OFF_CLOCK_SELECT_REG)
				clock_select_reg_reg <= pwdata[5:0];
			if (paddr == `SCM_OFF_PLL_CONTROL_REG)
				me_reg <= pwdata[0];
			if (paddr == `SCM_OFF_IRQEN)
				self_clock_enable_bit_reg <= pwdata[0];
		end
	end

	// A wake request in stop returns the mode to run and beats a software write.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_reg <= `SCM_MODE_RUN;
		else if (wake_req && state_reg == ST_STOP)
			mode_reg <= `SCM_MODE_RUN;
		else if (wr_en && paddr == `SCM_OFF_MODE)
			mode_reg <= pwdata[1:0];
	end

	// Sticky monitor failure flag, write one to clear; a new loss wins.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fail_flag_reg <= 1'b0;
		else if (cm_loss)
			fail_flag_reg <= 1'b1;
		else if (wr_en && paddr == `SCM_OFF_STATUS && pwdata[`SCM_STAT_FAIL])
			fail_flag_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// Clock distribution controls
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_src_sel <= `SCM_SRC_NONE;
			pll_mult    <= 7'h2;
			pll_div     <= 5'h1;
		end else begin
			pll_mult <= {mult_reg, 1'b0} + 7'h2;
			pll_div  <= {1'b0, ref_divider_reg_reg} + 5'h1;
			case (state_next)
				ST_RUN:  sys_src_sel <= pll_sel ? `SCM_SRC_PLL : `SCM_SRC_OSC;
				ST_SELF: sys_src_sel <= `SCM_SRC_SELF;
				default: sys_src_sel <= `SCM_SRC_NONE;
			endcase
		end
	end

	// The half-rate phase toggles on pclk while the system clock is connected, keeping
	// peripheral edges aligned with system edges.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			half_reg <= 1'b0;
		else if (sys_clk_connected)
			half_reg <= ~half_reg;
		else
			half_reg <= 1'b0;
	end

	assign sys_clk_connected = state_reg == ST_RUN || state_reg == ST_SELF;
	assign pll_self_clock    = state_reg == ST_SELF;
	assign ips_clk_en        = half_reg;
	assign flash_array_en    = half_reg;
	assign can_clk_osc       = {clock_select_reg_reg[`SCM_CSEL_CAN1],
		clock_select_reg_reg[`SCM_CSEL_CAN0]};
	assign pit_clk_pll       = clock_select_reg_reg[`SCM_CSEL_PIT];
	assign swt_clk_pll       = clock_select_reg_reg[`SCM_CSEL_SWT];
	assign osc_enable        = state_reg != ST_STOP ||
		clock_select_reg_reg[`SCM_CSEL_PSEUDO_STOP_SELECT];
	assign timer_clk_run     = osc_enable;
	assign doze_active       = mode_reg == `SCM_MODE_DOZE && state_reg == ST_RUN;
	assign clk_mon_reset_req = state_reg == ST_RESET;
endmodule
`default_nettype wire

// file: design/scm_consts.vh
// Constants for the system clock source and monitor block.
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCM_CLK_PERIOD_PS    8000
`define SCM_QC_WINDOW_NS     50000
`define SCM_QC_WINDOW_CYC    ((`SCM_QC_WINDOW_NS * 1000) / `SCM_CLK_PERIOD_PS)
`define SCM_QC_EDGES         64
`define SCM_OSC_KHZ          16000
`define SCM_STRAP_WAIT       2'h3

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SCM_OFF_MULT         8'h00
`define SCM_OFF_REF_DIVIDER_REG       8'h04
`define SCM_OFF_CLOCK_SELECT_REG       8'h08
`define SCM_OFF_PLL_CONTROL_REG       8'h0c
`define SCM_OFF_IRQEN        8'h10
`define SCM_OFF_STATUS       8'h14
`define SCM_OFF_MODE         8'h18
`define SCM_OFF_SYSFREQ      8'h1c
`define SCM_OFF_PLLFREQ      8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCM_CSEL_PLL         0
`define SCM_CSEL_PIT         1
`define SCM_CSEL_SWT         2
`define SCM_CSEL_PSEUDO_STOP_SELECT        3
`define SCM_CSEL_CAN0        4
`define SCM_CSEL_CAN1        5
`define SCM_STAT_FAIL        2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCM_RST_MULT         6'h00
`define SCM_RST_REF_DIVIDER_REG       4'h0
`define SCM_RST_CLOCK_SELECT_REG       6'h00
`define SCM_RST_ME           1'b1
`define SCM_RST_SELF_CLOCK_ENABLE_BIT         1'b1

// ----------------------------------------------------------------
// Low-power modes and system clock sources
// ----------------------------------------------------------------
`define SCM_MODE_RUN         2'h0
`define SCM_MODE_DOZE        2'h1
`define SCM_MODE_STOP        2'h2
`define SCM_SRC_NONE         2'h0
`define SCM_SRC_OSC          2'h1
`define SCM_SRC_PLL          2'h2
`define SCM_SRC_SELF         2'h3

`endif

// file: design/scm_sync.v
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module scm_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule
`default_nettype wire

// file: design/scm_qual_check.v
// Clock quality checker: counts oscillator edges inside a fixed window.
`timescale 1ns/1ps
`default_nettype none
module scm_qual_check #(
	parameter WINDOW_CYC = 6250,
	parameter EDGES      = 64
) (
	input  wire clk,
	input  wire rst_n,
	input  wire start,
	input  wire osc_edge,
	output wire busy,
	output reg  done,
	output reg  pass
);
	reg        busy_reg;
	reg [31:0] win_reg;
	reg [15:0] edge_reg;

	assign busy = busy_reg;

	// A check passes as soon as enough edges arrive; otherwise it fails
	// when the window runs out.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			win_reg  <= 32'h0;
			edge_reg <= 16'h0;
			done     <= 1'b0;
			pass     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy_reg) begin
				busy_reg <= 1'b1;
				win_reg  <= 32'h0;
				edge_reg <= 16'h0;
				pass     <= 1'b0;
			end else if (busy_reg) begin
				if (osc_edge)
					edge_reg <= edge_reg + 16'h1;
				win_reg <= win_reg + 32'h1;
				if (osc_edge && edge_reg == EDGES[15:0] - 16'h1) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
					pass     <= 1'b1;
				end else if (win_reg == WINDOW_CYC[31:0] - 32'h1) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
					pass     <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/scm_top_asserts.sv
// Concurrent checks on the ports of the clock source and monitor block.
`timescale 1ns/1ps
`default_nettype none
module scm_top_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        rc_timeout,
	input wire logic        rc_restart,
	input wire logic [1:0]  sys_src_sel,
	input wire logic        sys_clk_connected,
	input wire logic        pll_self_clock,
	input wire logic [6:0]  pll_mult,
	input wire logic [4:0]  pll_div,
	input wire logic        ips_clk_en,
	input wire logic        flash_array_en,
	input wire logic        osc_enable,
	input wire logic        clk_mon_reset_req
);
	logic [6:0] mult_exp;
	logic [4:0] div_exp;
	logic       sel_exp;
	wire        wr_osc = psel && penable && pwrite && !sel_exp;

	// Expected synthesiser factors, only tracked while the PLL is not selected.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mult_exp <= 7'h2;
			div_exp  <= 5'h1;
			sel_exp  <= 1'b0;
		end else begin
			if (psel && penable && pwrite && paddr == 8'h08)
				sel_exp <= pwdata[0];
			if (wr_osc && paddr == 8'h00)
				mult_exp <= {pwdata[5:0], 1'b0} + 7'h2;
			if (wr_osc && paddr == 8'h04)
				div_exp <= {1'b0, pwdata[3:0]} + 5'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Assertions and cover points
	// ----------------------------------------------------------------
	AST_PLL_MULT: assert property (wr_osc && paddr == 8'h00 |-> ##2 pll_mult == mult_exp)
		else $error("pll multiplier wrong");
	AST_PLL_DIV: assert property (wr_osc && paddr == 8'h04 |-> ##2 pll_div == div_exp)
		else $error("pll divider wrong");
	AST_IPS_TOGGLE: assert property (sys_clk_connected [*3] |-> ips_clk_en != $past(ips_clk_en))
		else $error("peripheral clock not half rate");
	AST_FLASH_TOGGLE: assert property (sys_clk_connected [*3] |-> flash_array_en != $past(flash_array_en))
		else $error("array clock not half rate");
	AST_SELF_SRC: assert property (pll_self_clock == (sys_src_sel == 2'h3))
		else $error("self clock and source disagree");
	AST_CONN_SRC: assert property (sys_clk_connected == (sys_src_sel != 2'h0))
		else $error("connection and source disagree");
	AST_OSC_STOP: assert property (!osc_enable |-> !sys_clk_connected)
		else $error("oscillator off while running");
	AST_EDGE_OK: assert property (rc_restart && (sys_src_sel == 2'h1 || sys_src_sel == 2'h2)
		|=> !pll_self_clock && !clk_mon_reset_req) else $error("failure despite edge");
	AST_RESET_HOLD: assert property (clk_mon_reset_req |=> clk_mon_reset_req)
		else $error("reset request dropped");
	AST_SELF_CAUSE: assert property ($rose(pll_self_clock) && $past(sys_src_sel) != 2'h0
		|-> $past(rc_timeout, 3)) else $error("self clock without timeout");
	AST_RESTART_PULSE: assert property (rc_restart |=> !rc_restart)
		else $error("monitor restart not a single pulse");

	COV_SELF: cover property ($rose(pll_self_clock));
	COV_RESET_REQ: cover property ($rose(clk_mon_reset_req));
	COV_PLL: cover property (sys_src_sel == 2'h2);
	COV_STOP: cover property ($fell(osc_enable));
endmodule

bind scm_top scm_top_asserts chk_i (
	.pclk              (pclk),
	.presetn           (presetn),
	.psel              (psel),
	.penable           (penable),
	.pwrite            (pwrite),
	.paddr             (paddr),
	.pwdata            (pwdata),
	.rc_timeout        (rc_timeout),
	.rc_restart        (rc_restart),
	.sys_src_sel       (sys_src_sel),
	.sys_clk_connected (sys_clk_connected),
	.pll_self_clock    (pll_self_clock),
	.pll_mult          (pll_mult),
	.pll_div           (pll_div),
	.ips_clk_en        (ips_clk_en),
	.flash_array_en    (flash_array_en),
	.osc_enable        (osc_enable),
	.clk_mon_reset_req (clk_mon_reset_req)
);
`default_nettype wire

// file: bench/scm_crystal_out_pin.sv
// Behavioural crystal source with the analog monitor delay beside it.
`timescale 1ns/1ps
`default_nettype none
module scm_crystal_out_pin #(
	parameter int HALF  = 32,
	parameter int RC_NS = 400
) (
	input  wire logic run,
	input  wire logic strap,
	input  wire logic osc_enable,
	output var  logic osc_clock,
	output var  logic rc_timeout,
	output wire logic osc_select_pin
);
	int idle;

	assign osc_select_pin = strap;

	// The 3 ns offset keeps every change away from the sampling clock edges.
	initial begin
		osc_clock  = 1'b0;
		rc_timeout = 1'b0;
		idle       = 0;
		#3;
		forever begin
			#HALF;
			if (!osc_enable)
				osc_clock = 1'b0;
			else if (run)
				osc_clock = ~osc_clock;
			idle = (run && osc_enable) ? 0 : idle + HALF;
			rc_timeout = (idle >= RC_NS);
		end
	end
endmodule
`default_nettype wire

// file: bench/test_scm_top.sv
// Self-checking bench for the clock source and monitor block.
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.vh"
module test_scm_top;
	logic        pclk, presetn, psel, penable, pwrite, wake_req, run, strap, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rd;
	int          fails, comparisons, cycles;
	wire         pready, pslverr, osc_clock, rc_timeout, osc_select_pin, rc_restart;
	wire         sys_clk_connected, pll_self_clock, ips_clk_en, flash_array_en;
	wire         pit_clk_pll, swt_clk_pll, timer_clk_run, osc_enable, osc_loop_mode;
	wire         doze_active, clk_mon_reset_req;
	wire [31:0]  prdata;
	wire [1:0]   sys_src_sel, can_clk_osc;
	wire [6:0]   pll_mult;
	wire [4:0]   pll_div;

	scm_top #(
		.QC_WINDOW_CYC (200),
		.QC_EDGES      (8)
	) dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.pready            (pready),
		.prdata            (prdata),
		.pslverr           (pslverr),
		.osc_clock         (osc_clock),
		.rc_timeout        (rc_timeout),
		.osc_select_pin    (osc_select_pin),
		.wake_req          (wake_req),
		.rc_restart        (rc_restart),
		.sys_src_sel       (sys_src_sel),
		.sys_clk_connected (sys_clk_connected),
		.pll_self_clock    (pll_self_clock),
		.pll_mult          (pll_mult),
		.pll_div           (pll_div),
		.ips_clk_en        (ips_clk_en),
		.flash_array_en    (flash_array_en),
		.can_clk_osc       (can_clk_osc),
		.pit_clk_pll       (pit_clk_pll),
		.swt_clk_pll       (swt_clk_pll),
		.timer_clk_run     (timer_clk_run),
		.osc_enable        (osc_enable),
		.osc_loop_mode     (osc_loop_mode),
		.doze_active       (doze_active),
		.clk_mon_reset_req (clk_mon_reset_req)
	);
	scm_crystal_out_pin crystal_out_pin (
		.run            (run),
		.strap          (strap),
		.osc_enable     (osc_enable),
		.osc_clock      (osc_clock),
		.rc_timeout     (rc_timeout),
		.osc_select_pin (osc_select_pin)
	);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic wsrc(input logic [1:0] s, input int n);
		for (int i = 0; i < n && sys_src_sel !== s; i++)
			@(negedge pclk);
		chk(32'(sys_src_sel), 32'(s));
	endtask

	task automatic wake();
		@(posedge pclk);
		wake_req <= 1'b1;
		@(posedge pclk);
		wake_req <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, wake_req, presetn} = 5'h0;
		paddr  = 8'h00;
		pwdata = 32'h0;
		run    = 1'b1;
		strap  = 1'b1;
		rst();
		wsrc(2'h1, 400);
		chk(32'(osc_loop_mode), 32'h1);
		rdc(`SCM_OFF_PLL_CONTROL_REG, 32'h1);
		rdc(`SCM_OFF_IRQEN, 32'h1);
		rdc(8'h44, 32'h0);
		chk(32'(err), 32'h1);
		wr(`SCM_OFF_MULT, 32'h5);
		wr(`SCM_OFF_REF_DIVIDER_REG, 32'h1);
		// The synthesiser outputs follow the registers one edge later.
		@(negedge pclk);
		chk(32'({pll_mult, pll_div}), {20'h0, 7'd12, 5'd2});
		rdc(`SCM_OFF_PLLFREQ, 32'd96000);
		wr(`SCM_OFF_CLOCK_SELECT_REG, 32'h1);
		wsrc(2'h2, 4);
		wr(`SCM_OFF_MULT, 32'h3f);
		rdc(`SCM_OFF_MULT, 32'h5);
		for (int i = 0; i < 4; i++) begin
			wr(`SCM_OFF_CLOCK_SELECT_REG, {26'h0, i[1:0], 1'b0, i[1:0], 1'b0});
			// The source select is registered, so give it one more edge.
			@(negedge pclk);
			chk(32'(can_clk_osc), 32'(i));
			chk(32'({swt_clk_pll, pit_clk_pll}), 32'(i));
			chk(32'(sys_src_sel), 32'h1);
		end
		wr(`SCM_OFF_MODE, 32'(`SCM_MODE_DOZE));
		chk(32'({doze_active, osc_enable}), 32'h3);
		wr(`SCM_OFF_CLOCK_SELECT_REG, 32'h8);
		wr(`SCM_OFF_MODE, 32'(`SCM_MODE_STOP));
		wsrc(2'h0, 4);
		chk(32'(osc_enable), 32'h1);
		wake();
		wsrc(2'h1, 400);
		wr(`SCM_OFF_CLOCK_SELECT_REG, 32'h0);
		wr(`SCM_OFF_MODE, 32'(`SCM_MODE_STOP));
		wsrc(2'h0, 4);
		chk(32'({osc_enable, timer_clk_run}), 32'h0);
		wake();
		wsrc(2'h1, 400);
		run <= 1'b0;
		wsrc(2'h3, 200);
		apb(1'b0, `SCM_OFF_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h7);
		repeat (300) @(negedge pclk);
		chk(32'(pll_self_clock), 32'h1);
		run <= 1'b1;
		wsrc(2'h1, 400);
		wr(`SCM_OFF_STATUS, 32'h4);
		apb(1'b0, `SCM_OFF_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h0);
		wr(`SCM_OFF_PLL_CONTROL_REG, 32'h0);
		run <= 1'b0;
		repeat (300) @(negedge pclk);
		chk(32'(sys_src_sel), 32'h1);
		run <= 1'b1;
		repeat (20) @(negedge pclk);
		wr(`SCM_OFF_PLL_CONTROL_REG, 32'h1);
		wr(`SCM_OFF_IRQEN, 32'h0);
		run <= 1'b0;
		repeat (300) @(negedge pclk);
		chk(32'({clk_mon_reset_req, sys_src_sel}), 32'h4);
		strap <= 1'b0;
		rst();
		wsrc(2'h3, 400);
		chk(32'(osc_loop_mode), 32'h0);
		run <= 1'b1;
		wsrc(2'h1, 400);
		end_sim();
	end
endmodule
`default_nettype wire
